// ===== option_cfg_pkg.sv
package option_cfg_pkg;

  // Flash addresses of the two option bytes.
  localparam logic [15:0] USER_OPT_ADDR = 16'h0000;
  localparam logic [15:0] SPARE_OPT_ADDR = 16'h0001;

  // Field positions inside the user option byte.
  localparam int TIMEOUT_ACTION_BIT = 7;
  localparam int ALWAYS_RUNNING_BIT = 6;
  localparam int OSC_DRIVE_HI = 5;
  localparam int OSC_DRIVE_LO = 4;
  localparam int BROWNOUT_BIT = 3;
  localparam int READ_GUARD_BIT = 2;
  localparam int RESERVED_BIT = 1;
  localparam int WRITE_GUARD_BIT = 0;

  // Erased flash reads all ones.
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Oscillator drive encodings.
  localparam logic [1:0] OSC_EXT_RC = 2'h0;
  localparam logic [1:0] OSC_LOW_POWER = 2'h1;
  localparam logic [1:0] OSC_MED_POWER = 2'h2;
  localparam logic [1:0] OSC_HIGH_POWER = 2'h3;

  // APB register map of the read-only status view and the keyed reload strobe.
  localparam logic [11:0] STATUS_ADDR = 12'h000;
  localparam logic [11:0] RELOAD_ADDR = 12'h004;
  localparam logic [31:0] RELOAD_KEY = 32'h0000_A55A;

endpackage : option_cfg_pkg

// ===== option_byte_config_decoder.sv
// Notes on behaviour
// - The first two flash bytes are option bytes, read as configuration, not code.
// - Timeout action bit 7 low: watchdog timeout raises an interrupt request.
// - Timeout action bit 7 high: watchdog timeout resets the device.
// - Always-running bit 6 low: watchdog runs from power-up and cannot be stopped.
// - Bit 6 high: watchdog starts on its instruction; only reset or recovery stops it.
// - Bits 5:4 pick oscillator drive: RC, low, medium or high power crystal.
// - Bit 3 keeps brown-out protection on in stop mode; low turns it off there.
// - Bit 2 low hides code and limits the debugger; high allows everything.
// - Bit 0 low blocks user program and erase; debugger mass erase still works.
// - Bit 0 high allows byte program and mass erase across all flash.
// - Erased bytes give reset on timeout, started watchdog by instruction, osc 11, readable.
// - No reset modifies the stored option bytes.
// - Every reset or stop recovery reloads the latches before the processor runs.
// - Changes to option bytes act only after the next reset, stop recovery or keyed APB reload reloads them.
// - Configuration latches are not reachable through the register file.
`timescale 1ns/1ns
module option_byte_config_decoder
(
  input wire logic clk,
  input wire logic rst,
  input wire logic stop_recovery,
  output logic cpu_hold,
  output logic flash_rd_en,
  output logic [15:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  input wire logic flash_rd_valid,
  output logic config_valid,
  output logic watchdog_timeout_action,
  output logic watchdog_always_running,
  output logic [1:0] oscillator_drive_select,
  output logic brownout_always_active,
  output logic code_read_guard,
  output logic flash_write_guard,
  output logic reserved_bit_violation,
  input wire logic watchdog_timeout,
  input wire logic watchdog_start_instruction,
  input wire logic in_stop_mode,
  input wire logic user_flash_write_req,
  input wire logic user_mass_erase_req,
  input wire logic debug_mass_erase_req,
  output logic watchdog_irq_req,
  output logic watchdog_reset_req,
  output logic watchdog_enabled,
  output logic brownout_enable,
  output logic code_readable,
  output logic debugger_full_access,
  output logic user_flash_write_grant,
  output logic mass_erase_grant,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef enum logic [3:0] {
    LOAD_USER = 4'h1,
    LOAD_SPARE = 4'h2,
    LOAD_WAIT = 4'h4,
    RUN = 4'h8
  } load_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Load sequence: both option bytes are fetched while the processor is held.

  load_state_t state_reg;
  load_state_t state_next;
  logic [7:0] user_byte_reg;
  logic [7:0] user_byte_next;
  logic [7:0] spare_byte_reg;
  logic [7:0] spare_byte_next;
  logic valid_reg;
  logic valid_next;
  logic watchdog_started_reg;
  logic watchdog_started_next;
  logic reload_req;
  logic apb_err;

  always_comb
  begin
    state_next = state_reg;
    user_byte_next = user_byte_reg;
    spare_byte_next = spare_byte_reg;
    valid_next = valid_reg;
    unique case (state_reg)
      LOAD_USER:
      begin
        if (flash_rd_valid)
        begin
          user_byte_next = flash_rd_data;
          state_next = LOAD_SPARE;
        end
      end
      LOAD_SPARE:
      begin
        if (flash_rd_valid)
        begin
          spare_byte_next = flash_rd_data;
          state_next = LOAD_WAIT;
        end
      end
      LOAD_WAIT:
      begin
        valid_next = 1'b1;
        state_next = RUN;
      end
      RUN:
      begin
        // A stop-mode recovery reloads just as a reset does.
        if (stop_recovery || reload_req)
        begin
          valid_next = 1'b0;
          state_next = LOAD_USER;
        end
      end
      default:
      begin
        state_next = LOAD_USER;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Latches start at the erased value until the fetch completes.
      state_reg <= LOAD_USER;
      user_byte_reg <= option_cfg_pkg::ERASED_BYTE;
      spare_byte_reg <= option_cfg_pkg::ERASED_BYTE;
      valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      user_byte_reg <= user_byte_next;
      spare_byte_reg <= spare_byte_next;
      valid_reg <= valid_next;
    end
  end

  // Flash is only ever read here, so a reset never alters its contents.
  assign flash_rd_en = (state_reg == LOAD_USER) || (state_reg == LOAD_SPARE);
  assign flash_rd_addr = (state_reg == LOAD_SPARE) ? option_cfg_pkg::SPARE_OPT_ADDR :
                         option_cfg_pkg::USER_OPT_ADDR;
  assign cpu_hold = !valid_reg;
  assign config_valid = valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded configuration from the latched copy.

  always_comb
  begin
    watchdog_timeout_action = user_byte_reg[option_cfg_pkg::TIMEOUT_ACTION_BIT];
    watchdog_always_running = user_byte_reg[option_cfg_pkg::ALWAYS_RUNNING_BIT];
    oscillator_drive_select =
      user_byte_reg[option_cfg_pkg::OSC_DRIVE_HI:option_cfg_pkg::OSC_DRIVE_LO];
    brownout_always_active = user_byte_reg[option_cfg_pkg::BROWNOUT_BIT];
    code_read_guard = user_byte_reg[option_cfg_pkg::READ_GUARD_BIT];
    flash_write_guard = user_byte_reg[option_cfg_pkg::WRITE_GUARD_BIT];
    // Reports a programmer that broke the reserved-ones convention.
    reserved_bit_violation = valid_reg &&
      (!user_byte_reg[option_cfg_pkg::RESERVED_BIT] ||
      (spare_byte_reg != option_cfg_pkg::ERASED_BYTE));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog start latch: once started only reset or recovery clears it.

  always_comb
  begin
    watchdog_started_next = watchdog_started_reg;
    if (stop_recovery)
    begin
      watchdog_started_next = 1'b0;
    end
    else if (valid_reg && watchdog_start_instruction)
    begin
      watchdog_started_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      watchdog_started_reg <= 1'b0;
    end
    else
    begin
      watchdog_started_reg <= watchdog_started_next;
    end
  end

  always_comb
  begin
    watchdog_enabled = valid_reg && (!watchdog_always_running || watchdog_started_reg);
    watchdog_irq_req = valid_reg && watchdog_timeout && !watchdog_timeout_action;
    watchdog_reset_req = valid_reg && watchdog_timeout && watchdog_timeout_action;
    brownout_enable = brownout_always_active || !in_stop_mode;
    code_readable = valid_reg && code_read_guard;
    debugger_full_access = valid_reg && code_read_guard;
    user_flash_write_grant = valid_reg && flash_write_guard && user_flash_write_req;
    mass_erase_grant = valid_reg && (debug_mass_erase_req ||
      (flash_write_guard && user_mass_erase_req));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: a read-only view of loader status and a keyed reload strobe.
  // The latches themselves cannot be written from here.

  logic access;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign apb_err = (paddr != option_cfg_pkg::STATUS_ADDR) &&
                   (paddr != option_cfg_pkg::RELOAD_ADDR);
  assign pslverr = access && (apb_err || (pwrite && paddr == option_cfg_pkg::STATUS_ADDR));
  // A reload stands in for a system reset request from software.
  assign reload_req = access && pwrite && (paddr == option_cfg_pkg::RELOAD_ADDR) &&
                      (pwdata == option_cfg_pkg::RELOAD_KEY);

  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  always_comb
  begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == option_cfg_pkg::STATUS_ADDR)
      begin
        // Only loader status; the option values stay hidden.
        prdata_next = {29'h0, reserved_bit_violation, watchdog_started_reg, valid_reg};
      end
      else
      begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // The reset term keeps the edge of reset release, where the latch is still forced, out.
  sequence s_user_fetch;
    !rst && flash_rd_en && flash_rd_addr == option_cfg_pkg::USER_OPT_ADDR && flash_rd_valid;
  endsequence

  sequence s_spare_fetch;
    flash_rd_en && flash_rd_addr == option_cfg_pkg::SPARE_OPT_ADDR && flash_rd_valid;
  endsequence

  a_load_user_byte: assert property (@(posedge clk) disable iff (rst)
    s_user_fetch |=> user_byte_reg == $past(flash_rd_data))
    else $error("User option byte not captured.");

  a_cpu_held_load: assert property (@(posedge clk) disable iff (rst)
    s_spare_fetch |=> cpu_hold ##1 !cpu_hold)
    else $error("Processor released at wrong time.");

  a_irq_on_timeout: assert property (@(posedge clk) disable iff (rst)
    valid_reg && watchdog_timeout && !user_byte_reg[7] |-> watchdog_irq_req && !watchdog_reset_req)
    else $error("Timeout did not raise interrupt.");

  a_reset_on_timeout: assert property (@(posedge clk) disable iff (rst)
    valid_reg && watchdog_timeout && user_byte_reg[7] |-> watchdog_reset_req && !watchdog_irq_req)
    else $error("Timeout did not request reset.");

  a_watchdog_forced_on: assert property (@(posedge clk) disable iff (rst)
    valid_reg && !user_byte_reg[6] |-> watchdog_enabled)
    else $error("Always-running watchdog off.");

  a_watchdog_stays_on: assert property (@(posedge clk) disable iff (rst)
    valid_reg && watchdog_start_instruction && !stop_recovery |=> watchdog_started_reg [*2]
      or stop_recovery or $fell(valid_reg) or ##1 stop_recovery)
    else $error("Started watchdog stopped early.");

  a_brownout_stop: assert property (@(posedge clk) disable iff (rst)
    in_stop_mode && !user_byte_reg[3] |-> !brownout_enable)
    else $error("Brown-out active in stop.");

  a_write_blocked: assert property (@(posedge clk) disable iff (rst)
    !user_byte_reg[0] && !debug_mass_erase_req |-> !user_flash_write_grant && !mass_erase_grant)
    else $error("Protected flash write granted.");

  a_write_allowed: assert property (@(posedge clk) disable iff (rst)
    valid_reg && user_byte_reg[0] && user_flash_write_req |-> user_flash_write_grant)
    else $error("Permitted write refused.");

  a_debug_access: assert property (@(posedge clk) disable iff (rst)
    valid_reg |-> debugger_full_access == user_byte_reg[2])
    else $error("Debugger access mismatch.");

  a_stable_config: assert property (@(posedge clk) disable iff (rst)
    valid_reg && $past(valid_reg) |-> $stable(oscillator_drive_select))
    else $error("Configuration changed between reloads.");

endmodule : option_byte_config_decoder

// ===== flash_option_model.sv
`timescale 1ns/1ns
module flash_option_model
(
  input wire logic clk,
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0] user_byte,
  input wire logic [7:0] spare_byte,
  input wire logic [3:0] delay,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  logic [3:0] wait_cnt;
  initial
  begin
    rd_data = 8'h00;
    rd_valid = 1'b0;
    wait_cnt = 4'h0;
  end
  // The array has no reset, so a reload reads whatever user_byte and spare_byte hold at that time.
  always @(posedge clk)
  begin
    if (rd_en && !rd_valid && wait_cnt >= delay)
    begin
      rd_valid <= 1'b1;
      rd_data <= (rd_addr == option_cfg_pkg::USER_OPT_ADDR) ? user_byte : spare_byte;
      wait_cnt <= 4'h0;
    end
    else
    begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      wait_cnt <= rd_en ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : flash_option_model

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  logic clk, rst, stop_recovery, cpu_hold, flash_rd_en, flash_rd_valid, config_valid, err;
  logic [15:0] flash_rd_addr;
  logic [7:0] flash_rd_data, ub, sb;
  logic [3:0] dly;
  logic [1:0] oscillator_drive_select;
  logic watchdog_timeout_action, watchdog_always_running, brownout_always_active;
  logic code_read_guard, flash_write_guard, reserved_bit_violation, watchdog_timeout;
  logic watchdog_start_instruction, in_stop_mode, user_flash_write_req, user_mass_erase_req;
  logic debug_mass_erase_req, watchdog_irq_req, watchdog_reset_req, watchdog_enabled;
  logic brownout_enable, code_readable, debugger_full_access, user_flash_write_grant;
  logic mass_erase_grant, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] cfg;
  logic [7:0] tu [4] = '{8'h02, 8'h57, 8'hAE, 8'hF9};
  logic [7:0] ts [4] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF};
  logic [3:0] td [4] = '{4'h3, 4'h1, 4'h0, 4'h5};
  int error_cnt, checked;

  option_byte_config_decoder dut
  (
    .clk, .rst, .stop_recovery, .cpu_hold, .flash_rd_en, .flash_rd_addr, .flash_rd_data,
    .flash_rd_valid, .config_valid, .watchdog_timeout_action, .watchdog_always_running,
    .oscillator_drive_select, .brownout_always_active, .code_read_guard, .flash_write_guard,
    .reserved_bit_violation, .watchdog_timeout, .watchdog_start_instruction, .in_stop_mode,
    .user_flash_write_req, .user_mass_erase_req, .debug_mass_erase_req, .watchdog_irq_req,
    .watchdog_reset_req, .watchdog_enabled, .brownout_enable, .code_readable,
    .debugger_full_access, .user_flash_write_grant, .mass_erase_grant, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
  );
  flash_option_model flash
  (
    .clk, .rd_en(flash_rd_en), .rd_addr(flash_rd_addr), .user_byte(ub), .spare_byte(sb),
    .delay(dly), .rd_data(flash_rd_data), .rd_valid(flash_rd_valid)
  );
  assign cfg = {watchdog_timeout_action, watchdog_always_running, oscillator_drive_select,
    brownout_always_active, code_read_guard, flash_write_guard};

  ////////////////////////////////////////////////////////////////
  task give_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk

  // Waits for the loaders first to drop config_valid when asked, then to finish.
  task wait_cfg(input bit drop);
    int i;
    for (i = 0; i < 40 && drop && config_valid !== 1'b0; i++)
      @(negedge clk);
    if (i == 40)
    begin
      error_cnt++;
      give_verdict();
    end
    for (i = 0; i < 200 && config_valid !== 1'b1; i++)
    begin
      chk("cpu_hold", 1, cpu_hold);
      @(negedge clk);
    end
    if (i == 200)
    begin
      error_cnt++;
      give_verdict();
    end
    chk("cpu_hold", 0, cpu_hold);
  endtask : wait_cfg

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      error_cnt++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task run_case(input logic [7:0] u, input logic [7:0] s, input logic [3:0] d);
    @(posedge clk);
    ub <= u;
    sb <= s;
    dly <= d;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_cfg(0);
    @(posedge clk);
    watchdog_timeout <= 1'b1;
    in_stop_mode <= 1'b1;
    user_flash_write_req <= 1'b1;
    user_mass_erase_req <= 1'b1;
    @(negedge clk);
    chk("fields", {u[7:2], u[0]}, cfg);
    chk("wdog", {~u[7], u[7], ~u[6]}, {watchdog_irq_req, watchdog_reset_req, watchdog_enabled});
    chk("bo_stop", u[3], brownout_enable);
    chk("read", {2{u[2]}}, {code_readable, debugger_full_access});
    chk("grant", {2{u[0]}}, {user_flash_write_grant, mass_erase_grant});
    chk("viol", !u[1] || s != 8'hFF, reserved_bit_violation);
    @(posedge clk);
    watchdog_timeout <= 1'b0;
    in_stop_mode <= 1'b0;
    user_mass_erase_req <= 1'b0;
    debug_mass_erase_req <= 1'b1;
    @(negedge clk);
    chk("dbg_erase", 3, {mass_erase_grant, brownout_enable});
    @(posedge clk);
    debug_mass_erase_req <= 1'b0;
    user_flash_write_req <= 1'b0;
  endtask : run_case

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    {rst, stop_recovery, watchdog_timeout, watchdog_start_instruction, in_stop_mode} = 5'h10;
    {user_flash_write_req, user_mass_erase_req, debug_mass_erase_req} = 3'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ub, sb, dly} = {8'hFF, 8'hFF, 4'h0};
    error_cnt = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_cfg(0);
    chk("erased", 7'h7F, cfg);
    for (int k = 0; k < 4; k++)
      run_case(tu[k], ts[k], td[k]);
    run_case(8'h57, 8'hFF, 4'h2);
    watchdog_start_instruction <= 1'b1;
    ub <= 8'hFF;
    @(posedge clk);
    watchdog_start_instruction <= 1'b0;
    repeat (10) @(negedge clk);
    chk("started", 1, watchdog_enabled);
    chk("held", 7'h2B, cfg);
    apb(1'b1, option_cfg_pkg::STATUS_ADDR, 32'hFFFF_FFFF);
    chk("wr_status_err", 1, err);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped_err", 1, err);
    apb(1'b0, option_cfg_pkg::STATUS_ADDR, 32'h0000_0000);
    chk("status", 32'h0000_0003, rd);
    chk("status_err", 0, err);
    apb(1'b1, option_cfg_pkg::RELOAD_ADDR, option_cfg_pkg::RELOAD_KEY);
    wait_cfg(1);
    chk("reloaded", 7'h7F, cfg);
    chk("still_on", 1, watchdog_enabled);
    @(posedge clk);
    ub <= 8'h57;
    stop_recovery <= 1'b1;
    @(posedge clk);
    stop_recovery <= 1'b0;
    wait_cfg(1);
    chk("recovered", 7'h2B, cfg);
    chk("wdog_off", 0, watchdog_enabled);
    give_verdict();
  end
endmodule : tb
